// [hw/temp_sensor_config_limit_regs.sv]
// configuration, rate, limit and scratch registers of a two-channel temperature monitor
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: config and rate answer at both addresses
// RULE_02: aliased limits share one storage location
// RULE_03: mask-all silences warning pin in interrupt mode
// RULE_04: standby bit stops periodic conversions
// RULE_05: warn mode one makes pin comparator
// RULE_06: bit four disables external resistance correction
// RULE_07: range bit selects binary or offset format
// RULE_08: averaging-disable bit caps averaging factor
// RULE_09: rate code bits 3-0, reset 06h
// RULE_10: codes 0-A map rates, B-F one/second
// RULE_11: temperature above high limit sets flag
// RULE_12: temperature at or below low limit sets flag
// RULE_13: host writes limits in range's format
// RULE_14: limits integer byte plus three fraction bits; the internal limits here hold the byte only
// RULE_15: standby limit edits wait for next conversion
// RULE_16: scratch bytes store value, reset zero
// RULE_17: flags stick until status read; in comparator mode they follow each conversion and reads do not clear them
// RULE_18: one-shot converts only in standby, idle
// RULE_19: unused config and rate bits read zero
module temp_sensor_config_limit_regs
  import tsense_pkg::*;
#(
  parameter int unsigned FASTEST_PERIOD_CYCLES = FASTEST_PERIOD
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  output var  logic        conv_start,
  input  wire logic        conv_done,
  input  wire logic [7:0]  int_temp,
  input  wire logic [10:0] ext_temp,
  output var  logic        standby,
  output var  logic        resistance_comp_off,
  output var  logic        range_ext,
  output var  logic        dynamic_averaging_off,
  output var  logic [3:0]  conversion_rate_code,
  output var  logic        warn_pin_o,
  output var  logic        warn_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0]  cfg;
  logic [7:0]  rate;
  logic [7:0]  int_hi;
  logic [7:0]  int_lo;
  logic [7:0]  ext_hi_int;
  logic [7:0]  ext_lo_int;
  logic [7:0]  ext_hi_frac;
  logic [7:0]  ext_lo_frac;
  logic [7:0]  scratch_a;
  logic [7:0]  scratch_b;
  logic [3:0]  flags;
  logic        busy;
  logic [7:0]  snap_int_hi;
  logic [7:0]  snap_int_lo;
  logic [10:0] snap_ext_hi;
  logic [10:0] snap_ext_lo;
  logic        tick;
  logic        one_shot_wr;
  logic        status_rd;
  logic        mask_all;
  logic        warn_mode;
  logic [3:0]  hit;
  logic        next_start;

  assign mask_all              = cfg[CFG_MASK_ALL_BIT];
  assign warn_mode             = cfg[CFG_WARN_MODE_BIT];
  assign standby               = cfg[CFG_STANDBY_BIT]; // RULE_04
  assign resistance_comp_off   = cfg[CFG_RCOMP_OFF_BIT]; // RULE_06
  assign range_ext             = cfg[CFG_RANGE_BIT]; // RULE_07
  assign dynamic_averaging_off = cfg[CFG_DAVG_OFF_BIT]; // RULE_08
  assign conversion_rate_code  = rate[RATE_MSB:0]; // RULE_09
  assign warn_pin_o            = 1'b0;
  assign one_shot_wr           = reg_wr && (reg_addr == ADDR_ONE_SHOT);
  assign status_rd             = reg_rd && (reg_addr == ADDR_STATUS);

  ////////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cfg         <= CFG_RESET;
      rate        <= RATE_RESET; // RULE_09
      int_hi      <= HI_LIMIT_RESET;
      int_lo      <= LO_LIMIT_RESET;
      ext_hi_int  <= HI_LIMIT_RESET;
      ext_lo_int  <= LO_LIMIT_RESET;
      ext_hi_frac <= FRAC_RESET;
      ext_lo_frac <= FRAC_RESET;
      scratch_a   <= SCRATCH_RESET; // RULE_16
      scratch_b   <= SCRATCH_RESET;
    end else if (reg_wr) begin
      if (is_pair(reg_addr, ADDR_CFG, ADDR_CFG_ALIAS)) begin
        cfg <= reg_wdata & CFG_WRITABLE; // RULE_01 RULE_19
      end
      if (is_pair(reg_addr, ADDR_RATE, ADDR_RATE_ALIAS)) begin
        rate <= reg_wdata & RATE_WRITABLE; // RULE_01 RULE_19
      end
      if (is_pair(reg_addr, ADDR_INT_HI, ADDR_INT_HI_ALIAS)) begin
        int_hi <= reg_wdata; // RULE_02
      end
      if (is_pair(reg_addr, ADDR_INT_LO, ADDR_INT_LO_ALIAS)) begin
        int_lo <= reg_wdata; // RULE_02
      end
      if (is_pair(reg_addr, ADDR_EXT_HI, ADDR_EXT_HI_ALIAS)) begin
        ext_hi_int <= reg_wdata; // RULE_02 RULE_14
      end
      if (is_pair(reg_addr, ADDR_EXT_LO, ADDR_EXT_LO_ALIAS)) begin
        ext_lo_int <= reg_wdata; // RULE_02 RULE_14
      end
      if (reg_addr == ADDR_EXT_HI_FRAC) begin
        ext_hi_frac <= reg_wdata & FRAC_WRITABLE; // RULE_14
      end
      if (reg_addr == ADDR_EXT_LO_FRAC) begin
        ext_lo_frac <= reg_wdata & FRAC_WRITABLE; // RULE_14
      end
      if (reg_addr == ADDR_SCRATCH_A) begin
        scratch_a <= reg_wdata; // RULE_16
      end
      if (reg_addr == ADDR_SCRATCH_B) begin
        scratch_b <= reg_wdata; // RULE_16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register reads, one cycle latency
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_STATUS: begin
          reg_rdata <= {busy, flags, 3'b000};
        end
        ADDR_CFG, ADDR_CFG_ALIAS: begin
          reg_rdata <= cfg; // RULE_01
        end
        ADDR_RATE, ADDR_RATE_ALIAS: begin
          reg_rdata <= rate; // RULE_01
        end
        ADDR_INT_HI, ADDR_INT_HI_ALIAS: begin
          reg_rdata <= int_hi; // RULE_02
        end
        ADDR_INT_LO, ADDR_INT_LO_ALIAS: begin
          reg_rdata <= int_lo; // RULE_02
        end
        ADDR_EXT_HI, ADDR_EXT_HI_ALIAS: begin
          reg_rdata <= ext_hi_int; // RULE_02
        end
        ADDR_EXT_LO, ADDR_EXT_LO_ALIAS: begin
          reg_rdata <= ext_lo_int; // RULE_02
        end
        ADDR_EXT_HI_FRAC: begin
          reg_rdata <= ext_hi_frac;
        end
        ADDR_EXT_LO_FRAC: begin
          reg_rdata <= ext_lo_frac;
        end
        ADDR_SCRATCH_A: begin
          reg_rdata <= scratch_a; // RULE_16
        end
        ADDR_SCRATCH_B: begin
          reg_rdata <= scratch_b;
        end
        default: begin
          reg_rdata <= READ_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion scheduling
  conv_timer #(
    .FASTEST_PERIOD_CYCLES(FASTEST_PERIOD_CYCLES)
  ) u_timer (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .run       (!standby), // RULE_04
    .rate_code (rate[RATE_MSB:0]),
    .tick      (tick)
  );

  // a tick that lands while busy is dropped rather than queued
  assign next_start = !busy && ((tick && !standby) || (one_shot_wr && standby)); // RULE_04 RULE_18

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
      busy       <= 1'b0;
    end else begin
      conv_start <= next_start;
      if (next_start) begin
        busy <= 1'b1;
      end else if (conv_done) begin
        busy <= 1'b0;
      end
    end
  end

  // limits are sampled at conversion start, so standby edits wait
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      snap_int_hi <= HI_LIMIT_RESET;
      snap_int_lo <= LO_LIMIT_RESET;
      snap_ext_hi <= {HI_LIMIT_RESET, FRAC_RESET[FRAC_MSB:FRAC_LSB]};
      snap_ext_lo <= {LO_LIMIT_RESET, FRAC_RESET[FRAC_MSB:FRAC_LSB]};
    end else if (next_start) begin
      snap_int_hi <= int_hi; // RULE_15
      snap_int_lo <= int_lo;
      snap_ext_hi <= {ext_hi_int, ext_hi_frac[FRAC_MSB:FRAC_LSB]}; // RULE_14
      snap_ext_lo <= {ext_lo_int, ext_lo_frac[FRAC_MSB:FRAC_LSB]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // limit comparison and status flags
  // unsigned compare is right for both binary and offset-binary formats
  always_comb begin
    hit                = 4'b0000;
    hit[FLAG_INT_HIGH] = int_temp > snap_int_hi; // RULE_11
    hit[FLAG_INT_LOW]  = int_temp <= snap_int_lo; // RULE_12
    hit[FLAG_EXT_HIGH] = ext_temp > snap_ext_hi; // RULE_11
    hit[FLAG_EXT_LOW]  = ext_temp <= snap_ext_lo; // RULE_12
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flags <= 4'b0000;
    end else if (warn_mode) begin
      // comparator mode tracks the latest result, reads do not clear
      if (conv_done) begin
        flags <= hit; // RULE_05 RULE_17
      end
    end else begin
      // set wins over a clearing read in the same cycle
      flags <= (status_rd ? 4'b0000 : flags) | (conv_done ? hit : 4'b0000); // RULE_17
    end
  end

  // open-drain warning pin, driven low while asserted
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      warn_pin_oe <= 1'b0;
    end else if (warn_mode) begin
      warn_pin_oe <= flags[FLAG_INT_HIGH] || flags[FLAG_EXT_HIGH]; // RULE_05
    end else begin
      warn_pin_oe <= (|flags) && !mask_all; // RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_cfg_alias;
    reg_wr && reg_addr == ADDR_CFG_ALIAS |=> cfg == ($past(reg_wdata) & CFG_WRITABLE);
  endproperty
  a_cfg_alias: assert property (p_cfg_alias) else $error("config alias write lost"); // RULE_01

  property p_rate_alias_read;
    reg_rd && !reg_wr && reg_addr == ADDR_RATE_ALIAS |=> reg_rdata == {4'h0, $past(rate[RATE_MSB:0])};
  endproperty
  a_rate_alias_read: assert property (p_rate_alias_read) else $error("rate alias read wrong"); // RULE_01

  property p_limit_alias;
    reg_wr && reg_addr == ADDR_INT_HI_ALIAS |=> int_hi == $past(reg_wdata);
  endproperty
  a_limit_alias: assert property (p_limit_alias) else $error("limit alias write lost"); // RULE_02

  property p_mask_all;
    (mask_all && !warn_mode) [*2] |-> !warn_pin_oe;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked pin asserted"); // RULE_03

  property p_standby_quiet;
    standby ##1 (standby && !one_shot_wr) |=> !conv_start;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("conversion in standby"); // RULE_04

  property p_cmp_mode;
    warn_mode && mask_all && (flags[FLAG_INT_HIGH] || flags[FLAG_EXT_HIGH]) |=> warn_pin_oe;
  endproperty
  a_cmp_mode: assert property (p_cmp_mode) else $error("comparator pin not asserted"); // RULE_05

  property p_range_write;
    reg_wr && reg_addr == ADDR_CFG |=> range_ext == $past(reg_wdata[CFG_RANGE_BIT]) &&
      resistance_comp_off == $past(reg_wdata[CFG_RCOMP_OFF_BIT]);
  endproperty
  a_range_write: assert property (p_range_write) else $error("config field not applied"); // RULE_07

  property p_high_flag;
    conv_done && int_temp > snap_int_hi |=> flags[FLAG_INT_HIGH];
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("high flag not set"); // RULE_11

  property p_low_flag;
    conv_done && ext_temp <= snap_ext_lo |=> flags[FLAG_EXT_LOW];
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag not set"); // RULE_12

  property p_sticky;
    flags[FLAG_INT_LOW] && !warn_mode && !status_rd |=> flags[FLAG_INT_LOW];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped before read"); // RULE_17

  property p_one_shot;
    one_shot_wr && standby && !busy |=> conv_start ##1 busy;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot ignored"); // RULE_18

  property p_snapshot_hold;
    !next_start |=> $stable(snap_int_hi) && $stable(snap_ext_hi);
  endproperty
  a_snapshot_hold: assert property (p_snapshot_hold) else $error("limit used before conversion"); // RULE_15

  property p_scratch;
    reg_wr && reg_addr == ADDR_SCRATCH_B ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == ADDR_SCRATCH_B
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch readback wrong"); // RULE_16

  c_one_shot:  cover property (one_shot_wr && standby && !busy ##1 conv_start);
  c_warn:      cover property (!warn_mode && !warn_pin_oe ##1 warn_pin_oe);
  c_clear:     cover property (status_rd && |flags ##1 flags == 4'b0000);
  c_cmp_conv:  cover property (warn_mode && conv_done && hit[FLAG_INT_HIGH]);

endmodule
`default_nettype wire

// [hw/tsense_pkg.sv]
// constants shared by the temperature monitor configuration and limit registers
package tsense_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] ADDR_STATUS       = 8'h02;
  localparam logic [7:0] ADDR_CFG          = 8'h03;
  localparam logic [7:0] ADDR_RATE         = 8'h04;
  localparam logic [7:0] ADDR_INT_HI       = 8'h05;
  localparam logic [7:0] ADDR_INT_LO       = 8'h06;
  localparam logic [7:0] ADDR_EXT_HI       = 8'h07;
  localparam logic [7:0] ADDR_EXT_LO       = 8'h08;
  localparam logic [7:0] ADDR_CFG_ALIAS    = 8'h09;
  localparam logic [7:0] ADDR_RATE_ALIAS   = 8'h0A;
  localparam logic [7:0] ADDR_INT_HI_ALIAS = 8'h0B;
  localparam logic [7:0] ADDR_INT_LO_ALIAS = 8'h0C;
  localparam logic [7:0] ADDR_EXT_HI_ALIAS = 8'h0D;
  localparam logic [7:0] ADDR_EXT_LO_ALIAS = 8'h0E;
  localparam logic [7:0] ADDR_ONE_SHOT     = 8'h0F;
  localparam logic [7:0] ADDR_SCRATCH_A    = 8'h11;
  localparam logic [7:0] ADDR_SCRATCH_B    = 8'h12;
  localparam logic [7:0] ADDR_EXT_HI_FRAC  = 8'h13;
  localparam logic [7:0] ADDR_EXT_LO_FRAC  = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and writable masks
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] RATE_RESET     = 8'h06;
  localparam logic [7:0] HI_LIMIT_RESET = 8'h55;
  localparam logic [7:0] LO_LIMIT_RESET = 8'h00;
  localparam logic [7:0] FRAC_RESET     = 8'h00;
  localparam logic [7:0] SCRATCH_RESET  = 8'h00;
  localparam logic [7:0] CFG_WRITABLE   = 8'hF6;
  localparam logic [7:0] RATE_WRITABLE  = 8'h0F;
  localparam logic [7:0] FRAC_WRITABLE  = 8'hE0;
  localparam logic [7:0] READ_ZERO      = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CFG_MASK_ALL_BIT  = 7;
  localparam int CFG_STANDBY_BIT   = 6;
  localparam int CFG_WARN_MODE_BIT = 5;
  localparam int CFG_RCOMP_OFF_BIT = 4;
  localparam int CFG_RANGE_BIT     = 2;
  localparam int CFG_DAVG_OFF_BIT  = 1;
  localparam int RATE_MSB          = 3;
  localparam int FRAC_MSB          = 7;
  localparam int FRAC_LSB          = 5;
  localparam int STAT_BUSY_BIT     = 7;
  localparam int STAT_FLAG_MSB     = 6;
  localparam int STAT_FLAG_LSB     = 3;
  // flag vector order: int_high, int_low, ext_high, ext_low
  localparam int FLAG_INT_HIGH     = 3;
  localparam int FLAG_INT_LOW      = 2;
  localparam int FLAG_EXT_HIGH     = 1;
  localparam int FLAG_EXT_LOW      = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // conversion timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned FASTEST_RATE_HZ = 64;
  localparam int unsigned FASTEST_PERIOD  = CLK_HZ / FASTEST_RATE_HZ;
  localparam logic [3:0]  RATE_CODE_MAX   = 4'hA;
  localparam logic [3:0]  RATE_CODE_1HZ   = 4'h4;

  function automatic logic is_pair(input logic [7:0] addr, input logic [7:0] a, input logic [7:0] b);
    return (addr == a) || (addr == b);
  endfunction

endpackage

// [hw/conv_timer.sv]
// conversion rate timer: periodic start ticks from the rate code
`timescale 1ns/1ps
`default_nettype none
module conv_timer
  import tsense_pkg::*;
#(
  parameter int unsigned FASTEST_PERIOD_CYCLES = FASTEST_PERIOD
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [3:0] rate_code,
  output var  logic       tick
);

  logic [3:0]  eff_code;
  logic [3:0]  shift;
  logic [31:0] period;
  logic [31:0] count;
  logic        run_q;
  logic        fire;

  // reserved codes fall back to one per second
  assign eff_code = (rate_code > RATE_CODE_MAX) ? RATE_CODE_1HZ : rate_code; // RULE_10
  assign shift    = RATE_CODE_MAX - eff_code;
  assign period   = 32'(FASTEST_PERIOD_CYCLES) << shift; // RULE_10
  // fires at once when running starts, so leaving standby converts immediately
  assign fire     = run && (!run_q || (count >= period - 32'd1)); // RULE_15

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      count <= 32'd0;
      tick  <= 1'b0;
    end else begin
      run_q <= run;
      tick  <= fire;
      if (!run || fire) begin
        count <= 32'd0;
      end else begin
        count <= count + 32'd1;
      end
    end
  end

endmodule
`default_nettype wire

// [tb/adc_model.sv]
// converter stand-in: answers each conversion start that arrives while idle with results after a fixed delay
`timescale 1ns/1ps
`default_nettype none
module adc_model #(
  parameter int DELAY = 3
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        conv_start,
  input  wire logic [7:0]  int_val,
  input  wire logic [10:0] ext_val,
  output var  logic        conv_done,
  output var  logic [7:0]  int_temp,
  output var  logic [10:0] ext_temp,
  output var  int          n_start
);
  int cnt;

  ////////////////////////////////////////////////////////////////
  // results are valid only with conv_done; they toggle otherwise
  // so that a stale sample never looks right
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt       <= 0;
      n_start   <= 0;
      conv_done <= 1'b0;
      int_temp  <= 8'h00;
      ext_temp  <= 11'h000;
    end else begin
      conv_done <= 1'b0;
      int_temp  <= ~int_temp;
      ext_temp  <= ~ext_temp;
      if (cnt == 1) begin
        conv_done <= 1'b1;
        int_temp  <= int_val;
        ext_temp  <= ext_val;
      end
      if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      // a start while still converting cannot restart the converter
      if (conv_start && cnt == 0) begin
        cnt     <= DELAY;
        n_start <= n_start + 1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// register-level testbench for the temperature monitor configuration and limit registers
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tsense_pkg::*;
();
  localparam int FAST = 8;
  localparam logic [7:0] RST_ADDR [17] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B,
                                          8'h0C, 8'h0D, 8'h0E, 8'h11, 8'h12, 8'h13, 8'h14, 8'h30};
  localparam logic [7:0] RST_VAL  [17] = '{8'h00, 8'h06, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h06, 8'h55,
                                          8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  int_val   = 8'h20;
  logic [10:0] ext_val   = 11'h100;
  logic [7:0]  reg_rdata;
  logic        conv_start;
  logic        conv_done;
  logic [7:0]  int_temp;
  logic [10:0] ext_temp;
  logic        standby;
  logic        resistance_comp_off;
  logic        range_ext;
  logic        dynamic_averaging_off;
  logic [3:0]  conversion_rate_code;
  logic        warn_pin_o;
  logic        warn_pin_oe;
  int          n_start;
  int          n_mismatch = 0;
  int          checks     = 0;
  logic [3:0]  cfg_out;

  assign cfg_out = {standby, resistance_comp_off, range_ext, dynamic_averaging_off};

  always #25 core_clk = ~core_clk;

  temp_sensor_config_limit_regs #(.FASTEST_PERIOD_CYCLES(FAST)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_done(conv_done),
    .int_temp(int_temp), .ext_temp(ext_temp), .standby(standby), .resistance_comp_off(resistance_comp_off),
    .range_ext(range_ext), .dynamic_averaging_off(dynamic_averaging_off),
    .conversion_rate_code(conversion_rate_code), .warn_pin_o(warn_pin_o), .warn_pin_oe(warn_pin_oe));

  adc_model #(.DELAY(3)) i_adc (
    .core_clk(core_clk), .rst_n(rst_n), .conv_start(conv_start), .int_val(int_val), .ext_val(ext_val),
    .conv_done(conv_done), .int_temp(int_temp), .ext_temp(ext_temp), .n_start(n_start));

  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic timeout(input string name);
    n_mismatch++;
    $display("[FAIL] %s expected event seen none", name);
    finish_test();
  endtask

  // strobes last exactly one cycle, launched and dropped at falling edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(name, {24'h0, exp}, {24'h0, reg_rdata});
  endtask

  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (conv_start !== 1'b1 && n < 20000);
    if (n >= 20000) timeout("conv_start");
  endtask

  task automatic one_shot();
    int n;
    n = 0;
    wr(ADDR_ONE_SHOT, 8'h00);
    while (conv_done !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 100) timeout("conv_done");
    repeat (3) @(negedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    int d;
    logic [7:0] m;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 17; i++) rd(RST_ADDR[i], RST_VAL[i], "reset value");
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 8'hF6 : (i == 1) ? 8'h0F : 8'hFF;
      wr(8'h09 + 8'(i), 8'hFF);
      rd(8'h03 + 8'(i), m, "alias read");
      if (i == 0) chk("cfg outputs", 32'hF, {28'h0, cfg_out});
      if (i == 1) chk("rate code", 32'hF, {28'h0, conversion_rate_code});
      wr(8'h03 + 8'(i), 8'h5A);
      rd(8'h09 + 8'(i), 8'h5A & m, "alias read");
      if (i == 0) chk("cfg outputs", 32'hD, {28'h0, cfg_out});
    end
    wr(ADDR_EXT_HI_FRAC, 8'hFF);
    rd(ADDR_EXT_HI_FRAC, 8'hE0, "frac");
    wr(ADDR_SCRATCH_A, 8'hA5);
    wr(ADDR_SCRATCH_B, 8'h5A);
    rd(ADDR_SCRATCH_B, 8'h5A, "scratch b");
    rd(ADDR_SCRATCH_A, 8'hA5, "scratch a");
    rd(ADDR_CFG, 8'h52, "cfg untouched");
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00, "unmapped");
    // standby, interrupt mode; limits in plain binary as the range asks
    wr(ADDR_INT_HI, 8'h30);
    wr(ADDR_INT_LO, 8'h30);
    wr(ADDR_EXT_HI, 8'h1F);
    wr(ADDR_EXT_LO, 8'h20);
    wr(ADDR_EXT_LO_FRAC, 8'h00);
    rd(ADDR_STATUS, 8'h00, "status idle");
    int_val = 8'h31;
    ext_val = {8'h20, 3'b000};
    one_shot();
    chk("warn oe", 32'h1, {31'h0, warn_pin_oe});
    rd(ADDR_STATUS, 8'h58, "status hits");
    rd(ADDR_STATUS, 8'h00, "status cleared");
    chk("warn oe", 32'h0, {31'h0, warn_pin_oe});
    // equal to high limit is no hit, equal to low limit is
    int_val = 8'h30;
    ext_val = {8'h1F, 3'b111};
    one_shot();
    rd(ADDR_STATUS, 8'h28, "status edges");
    rd(ADDR_STATUS, 8'h00, "status cleared");
    wr(ADDR_CFG, 8'hC0);
    int_val = 8'h31;
    one_shot();
    chk("warn oe masked", 32'h0, {31'h0, warn_pin_oe});
    rd(ADDR_STATUS, 8'h48, "status masked");
    wr(ADDR_CFG, 8'hE0);
    one_shot();
    chk("warn oe cmp", 32'h1, {31'h0, warn_pin_oe});
    chk("warn data", 32'h0, {31'h0, warn_pin_o});
    wr(ADDR_INT_HI, 8'h40);
    repeat (10) @(negedge core_clk);
    chk("warn oe held", 32'h1, {31'h0, warn_pin_oe});
    one_shot();
    chk("warn oe cmp", 32'h0, {31'h0, warn_pin_oe});
    d = n_start;
    repeat (600) @(negedge core_clk);
    chk("standby starts", 32'(d), 32'(n_start));
    // active mode: period between starts for every rate code
    wr(ADDR_CFG, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_RATE, 8'(c));
      wait_start(d);
      wait_start(d);
      wait_start(d);
      chk("rate period", (c > 10) ? 32'(FAST << 6) : 32'(FAST << (10 - c)), 32'(d));
    end
    finish_test();
  end
endmodule
`default_nettype wire
